// ==== gpc_top.sv ====
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "gpc_cfg.svh"

module gpc_top
#(
  parameter int PINS    = 32,
  parameter int RST_PIN = 31
)
(
  input  wire logic                  clock,      // 50 MHz system clock
  input  wire logic                  reset_n,    // Main rail reset, synchronous
  input  wire gpc_pkg::gpc_addr_t    addr,       // Register byte address
  input  wire gpc_pkg::gpc_word_t    wdata,      // Write data
  input  wire logic                  wr_stb,     // Write strobe
  input  wire logic                  rd_stb,     // Read strobe
  output gpc_pkg::gpc_word_t         rdata,      // Read data, cycle after strobe
  input  wire logic [PINS-1:0]       pad_in,     // Pad input levels
  output logic [PINS-1:0]            pad_out,    // Pad output levels
  output logic [PINS-1:0]            pad_oe,     // Pad output enables
  output logic [PINS-1:0]            pull_up,    // Pull-up enables
  output logic [PINS-1:0]            pull_dn,    // Pull-down enables
  output logic [2*PINS-1:0]          drive_str,  // Drive strength, 2 bits per pin
  output logic [PINS-1:0]            slew_lim,   // Slew limit enables
  input  wire logic [PINS-1:0]       alt_out,    // Alternate function output data
  input  wire logic [PINS-1:0]       alt_oe,     // Alternate function output enable
  output logic [PINS-1:0]            alt_in,     // Synchronized pad input to functions
  output logic [2*PINS-1:0]          alt_sel,    // Mux setting, 2 bits per pin
  output logic                       irq,        // Level interrupt
  output logic                       wake,       // Wake request level
  output logic                       sys_reset   // System reset request, high active
);
  import gpc_pkg::*;

  // ****************************************************************
  // Per-pin configuration
  // ****************************************************************
  gpc_pull_t          pull_r [PINS];
  gpc_det_t           det_r  [PINS];
  gpc_mux_t           mux_r  [PINS];
  gpc_drv_t           drv_r  [PINS];
  logic [PINS-1:0]    od_r;
  logic [PINS-1:0]    dir_r;
  logic [PINS-1:0]    gsel_r;
  logic [PINS-1:0]    oval_r;
  logic [PINS-1:0]    slew_r;
  logic [PINS-1:0]    out_grp_r;
  logic [PINS-1:0]    mask_r;
  logic [PINS-1:0]    wake_en_r;
  logic [PINS-1:0]    stat_r;
  logic [PINS-1:0]    stat_nxt;
  logic [PINS-1:0]    sync1_r;
  logic [PINS-1:0]    sync2_r;
  logic [PINS-1:0]    prev_r;
  logic [2:0]         fill_r;
  logic [PINS-1:0]    event_w;
  logic [PINS-1:0]    drv_val;
  logic [PINS-1:0]    drv_en;
  gpc_word_t          rdata_nxt;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic in_region(input gpc_addr_t a, input logic [2:0] reg_id);
    logic [6:0] idx;
    idx       = a[8:2];
    in_region = (a[11:9] == reg_id) && (a[1:0] == 2'h0) && (int'(idx) < PINS);
  endfunction

  function automatic int pin_of(input gpc_addr_t a);
    pin_of = int'(a[8:2]);
  endfunction

  function automatic logic detect(input gpc_det_t d, input logic cur, input logic prv);
    unique case (d)
      `GPC_DET_LOW:  detect = ~cur;
      `GPC_DET_HIGH: detect = cur;
      `GPC_DET_RISE: detect = cur & ~prv;
      `GPC_DET_FALL: detect = ~cur & prv;
      `GPC_DET_BOTH: detect = cur ^ prv;
      default:       detect = 1'b0;
    endcase
  endfunction

  wire wr_ctrl1 = wr_stb && in_region(addr, `GPC_CTRL1_REGION);
  wire wr_ctrl2 = wr_stb && in_region(addr, `GPC_CTRL2_REGION);
  wire rd_stat  = rd_stb && (addr == `GPC_STAT_OFS);

  // ****************************************************************
  // Input synchronizer
  // ****************************************************************
  // The first stage feeds only the second; all logic reads sync2_r.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end
    else
    begin
      sync1_r <= pad_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // ****************************************************************
  // Synchronizer fill
  // ****************************************************************
  // The chain restarts at zero, which reads as a low pad. Until it has
  // filled, neither the reset request nor the event logic may trust it,
  // or every reset would be followed by a false reset request.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      fill_r <= '0;
    end
    else
    begin
      fill_r <= {fill_r[1:0], 1'b1};
    end
  end

  // ****************************************************************
  // Control register 1
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < PINS; i++)
      begin
        pull_r[i] <= `GPC_PULL_NONE;
        det_r[i]  <= `GPC_DET_OFF;
        mux_r[i]  <= `GPC_MUX_GPIO;
      end
      od_r   <= '0;
      dir_r  <= '0;
      gsel_r <= '0;
      oval_r <= '0;
    end
    else if (wr_ctrl1)
    begin
      pull_r[pin_of(addr)] <= wdata[`GPC_PULL_LSB +: 2];
      det_r[pin_of(addr)]  <= wdata[`GPC_DET_LSB +: 3];
      mux_r[pin_of(addr)]  <= wdata[`GPC_MUX_LSB +: 2];
      od_r[pin_of(addr)]   <= wdata[`GPC_OD_BIT];
      dir_r[pin_of(addr)]  <= wdata[`GPC_DIR_BIT];
      gsel_r[pin_of(addr)] <= wdata[`GPC_GSEL_BIT];
      oval_r[pin_of(addr)] <= wdata[`GPC_OVAL_BIT];
    end
  end

  // ****************************************************************
  // Control register 2
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < PINS; i++)
      begin
        drv_r[i] <= `GPC_RST_DRV;
      end
      slew_r <= '0;
    end
    else if (wr_ctrl2)
    begin
      drv_r[pin_of(addr)]  <= wdata[`GPC_DRV_LSB +: 2];
      slew_r[pin_of(addr)] <= wdata[`GPC_SLEW_BIT];
    end
  end

  // ****************************************************************
  // Group output, mask and wake enable
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      out_grp_r <= '0;
      mask_r    <= '0;
      wake_en_r <= '0;
    end
    else if (wr_stb)
    begin
      if (addr == `GPC_OUT_OFS)
      begin
        out_grp_r <= wdata[PINS-1:0];
      end
      if (addr == `GPC_MASK_OFS)
      begin
        mask_r <= wdata[PINS-1:0];
      end
      if (addr == `GPC_WAKE_EN_OFS)
      begin
        wake_en_r <= wdata[PINS-1:0];
      end
    end
  end

  // ****************************************************************
  // Event detection and status
  // ****************************************************************
  // A level event keeps setting its bit, so a read only clears it once
  // the level has gone; an event in the clearing cycle is kept.
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      event_w[i] = fill_r[2] & detect(det_r[i], sync2_r[i], prev_r[i]);
    end
    stat_nxt = (rd_stat ? '0 : stat_r) | event_w;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      stat_r <= '0;
      irq    <= 1'b0;
      wake   <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      irq    <= |(stat_nxt & mask_r);
      wake   <= |(stat_nxt & wake_en_r);
    end
  end

  // ****************************************************************
  // Pad drive
  // ****************************************************************
  // Open drain only ever drives low; a high value releases the pad.
  always_comb
  begin
    for (int i = 0; i < PINS; i++)
    begin
      if (mux_r[i] == `GPC_MUX_GPIO)
      begin
        drv_val[i] = gsel_r[i] ? out_grp_r[i] : oval_r[i];
        drv_en[i]  = dir_r[i];
      end
      else
      begin
        drv_val[i] = alt_out[i];
        drv_en[i]  = alt_oe[i];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pad_out   <= '0;
      pad_oe    <= '0;
      pull_up   <= '0;
      pull_dn   <= '0;
      drive_str <= '0;
      slew_lim  <= '0;
      alt_in    <= '0;
      alt_sel   <= '0;
    end
    else
    begin
      pad_out  <= drv_val & ~od_r;
      pad_oe   <= drv_en & ~(od_r & drv_val);
      slew_lim <= slew_r;
      alt_in   <= sync2_r;
      for (int i = 0; i < PINS; i++)
      begin
        pull_up[i]           <= (pull_r[i] == `GPC_PULL_UP);
        pull_dn[i]           <= (pull_r[i] == `GPC_PULL_DOWN);
        drive_str[2*i +: 2]  <= drv_r[i];
        alt_sel[2*i +: 2]    <= mux_r[i];
      end
    end
  end

  // ****************************************************************
  // System reset pin
  // ****************************************************************
  // Taken from the synchronized pad whatever the mux says.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      sys_reset <= 1'b0;
    end
    else
    begin
      sys_reset <= fill_r[1] & ~sync2_r[RST_PIN];
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb
  begin
    rdata_nxt = '0;
    if (in_region(addr, `GPC_CTRL1_REGION))
    begin
      rdata_nxt[`GPC_PULL_LSB +: 2] = pull_r[pin_of(addr)];
      rdata_nxt[`GPC_DET_LSB +: 3]  = det_r[pin_of(addr)];
      rdata_nxt[`GPC_OD_BIT]        = od_r[pin_of(addr)];
      rdata_nxt[`GPC_DIR_BIT]       = dir_r[pin_of(addr)];
      rdata_nxt[`GPC_GSEL_BIT]      = gsel_r[pin_of(addr)];
      rdata_nxt[`GPC_MUX_LSB +: 2]  = mux_r[pin_of(addr)];
      rdata_nxt[`GPC_OVAL_BIT]      = oval_r[pin_of(addr)];
      rdata_nxt[`GPC_PAD_BIT]       = sync2_r[pin_of(addr)];
    end
    else if (in_region(addr, `GPC_CTRL2_REGION))
    begin
      rdata_nxt[`GPC_SLEW_BIT]     = slew_r[pin_of(addr)];
      rdata_nxt[`GPC_DRV_LSB +: 2] = drv_r[pin_of(addr)];
    end
    else
    begin
      unique case (addr)
        `GPC_OUT_OFS:     rdata_nxt[PINS-1:0] = out_grp_r;
        `GPC_IN_OFS:      rdata_nxt[PINS-1:0] = sync2_r;
        `GPC_STAT_OFS:    rdata_nxt[PINS-1:0] = stat_r;
        `GPC_MASK_OFS:    rdata_nxt[PINS-1:0] = mask_r;
        `GPC_WAKE_EN_OFS: rdata_nxt[PINS-1:0] = wake_en_r;
        default:          rdata_nxt = '0;
      endcase
    end
  end

  // Read data stand for one cycle per cycle of read strobe, then return to zero.
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rdata <= `GPC_RST_WORD;
    end
    else
    begin
      rdata <= rd_stb ? rdata_nxt : '0;
    end
  end

endmodule // gpc_top

// ==== gpc_cfg.svh ====
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define GPC_ADDR_W       12
`define GPC_CTRL1_REGION 3'h0
`define GPC_CTRL2_REGION 3'h1
`define GPC_OUT_OFS      12'h400
`define GPC_IN_OFS       12'h404
`define GPC_STAT_OFS     12'h408
`define GPC_MASK_OFS     12'h40c
`define GPC_WAKE_EN_OFS  12'h410

// ****************************************************************
// Control register 1 fields
// ****************************************************************
`define GPC_PULL_LSB  0
`define GPC_DET_LSB   4
`define GPC_OD_BIT    8
`define GPC_DIR_BIT   9
`define GPC_GSEL_BIT  10
`define GPC_MUX_LSB   12
`define GPC_OVAL_BIT  16
`define GPC_PAD_BIT   24

// ****************************************************************
// Control register 2 fields
// ****************************************************************
`define GPC_SLEW_BIT  0
`define GPC_DRV_LSB   4

// ****************************************************************
// Field codes and reset values
// ****************************************************************
`define GPC_DET_LOW   3'h0
`define GPC_DET_HIGH  3'h1
`define GPC_DET_OFF   3'h4
`define GPC_DET_RISE  3'h5
`define GPC_DET_FALL  3'h6
`define GPC_DET_BOTH  3'h7
`define GPC_PULL_NONE 2'h0
`define GPC_PULL_UP   2'h1
`define GPC_PULL_DOWN 2'h2
`define GPC_MUX_GPIO  2'h0
`define GPC_RST_DRV   2'h0
`define GPC_RST_WORD  32'h0000_0000
`endif

// ==== gpc_pkg.sv ====
package gpc_pkg;
  typedef logic [2:0]  gpc_det_t;
  typedef logic [1:0]  gpc_pull_t;
  typedef logic [1:0]  gpc_mux_t;
  typedef logic [1:0]  gpc_drv_t;
  typedef logic [11:0] gpc_addr_t;
  typedef logic [31:0] gpc_word_t;
endpackage

// ==== gpc_top_sva.sv ====
`timescale 1ns/1ps
module gpc_top_chk
#(
  parameter int PINS    = 32,
  parameter int RST_PIN = 31
)
(
  input wire logic               clock,     // Clock
  input wire logic               reset_n,   // Reset
  input wire gpc_pkg::gpc_addr_t addr,      // Address
  input wire gpc_pkg::gpc_word_t wdata,     // Write data
  input wire logic               wr_stb,    // Write
  input wire logic               rd_stb,    // Read
  input wire gpc_pkg::gpc_word_t rdata,     // Read data
  input wire logic [PINS-1:0]    pad_in,    // Pads
  input wire logic [PINS-1:0]    pad_out,   // Pad data
  input wire logic [PINS-1:0]    pad_oe,    // Pad enable
  input wire logic [PINS-1:0]    pull_up,   // Pull-up
  input wire logic [PINS-1:0]    pull_dn,   // Pull-down
  input wire logic [2*PINS-1:0]  drive_str, // Strength
  input wire logic [PINS-1:0]    slew_lim,  // Slew
  input wire logic [PINS-1:0]    alt_in,    // Synced pads
  input wire logic               irq,       // Interrupt
  input wire logic               wake,      // Wake
  input wire logic               sys_reset  // Reset request
);
  import gpc_pkg::*;
  // ********
  // Port relations
  // ********
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  logic wr0;
  logic pp0;
  logic od0;
  logic wrd;
  logic mk;
  logic wk;
  logic rst_pad;
  assign wr0 = wr_stb && addr == 12'h000;
  assign pp0 = wr0 && wdata[13:8] == 6'h02;
  assign od0 = wr0 && wdata[13:8] == 6'h03;
  assign wrd = wr_stb && addr == 12'h200;
  assign mk = wr_stb && addr == 12'h40c;
  assign wk = wr_stb && addr == 12'h410;
  assign rst_pad = pad_in[RST_PIN];
  // Reset is part of the steady window so the synchronizer flush after release is never judged.
  sequence s_steady;
    (reset_n && $stable(pad_in))[*4];
  endsequence
  AST_SYNC: assert property (s_steady |-> alt_in == $past(pad_in))
    else $error("alt_in differs from steady pad");
  AST_IN: assert property (s_steady ##0 (rd_stb && addr == 12'h404) |=> rdata[PINS-1:0] == $past(pad_in))
    else $error("input register differs from pad");
  AST_RST_PIN: assert property ((reset_n && $stable(rst_pad))[*4] |-> sys_reset == !rst_pad)
    else $error("sys_reset does not follow reset pin");
  AST_RST_QUIET: assert property ($rose(reset_n) |-> (!sys_reset)[*3])
    else $error("sys_reset raised while synchronizer refills");
  AST_PIN_OUT: assert property (pp0 ##1 !wr0 |=> pad_oe[0] && pad_out[0] == $past(wdata[16], 2))
    else $error("pin0 push-pull output wrong");
  AST_OD: assert property (od0 ##1 !wr0 |=> !pad_out[0] && pad_oe[0] == !$past(wdata[16], 2))
    else $error("pin0 open-drain output wrong");
  AST_PULL: assert property (wr0 && wdata[1:0] == 2'h1 ##1 !wr0 |=> pull_up[0] && !pull_dn[0])
    else $error("pin0 pull-up not set");
  AST_DRIVE: assert property (wrd ##1 !wrd |=> drive_str[1:0] == $past(wdata[5:4], 2) && slew_lim[0] == $past(wdata[0], 2))
    else $error("pin0 drive or slew wrong");
  AST_MASK: assert property (mk && wdata == 32'h0 ##1 !mk |=> !irq)
    else $error("irq high with mask clear");
  AST_WAKE: assert property (wk && wdata == 32'h0 ##1 !wk |=> !wake)
    else $error("wake high with wake enable clear");
  COV_IRQ: cover property ($rose(irq));
  COV_WAKE: cover property ($rose(wake));
  COV_RST: cover property ($rose(sys_reset));
endmodule // gpc_top_chk

bind gpc_top gpc_top_chk #(.PINS(PINS), .RST_PIN(RST_PIN)) i_chk (.clock(clock), .reset_n(reset_n), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out),
  .pad_oe(pad_oe), .pull_up(pull_up), .pull_dn(pull_dn), .drive_str(drive_str), .slew_lim(slew_lim),
  .alt_in(alt_in), .irq(irq), .wake(wake), .sys_reset(sys_reset));

// ==== gpc_board.sv ====
`timescale 1ns/1ps
module gpc_board
(
  input  wire logic        clock,   // Clock
  input  wire logic [31:0] drv,     // Board level
  input  wire logic [31:0] drv_en,  // Board drives
  input  wire logic [31:0] pad_out, // Chip level
  input  wire logic [31:0] pad_oe,  // Chip drives
  input  wire logic [31:0] pull_up, // Pull-up on
  input  wire logic [31:0] pull_dn, // Pull-down on
  output logic [31:0]      pad_in   // Wire level
);
  // ********
  // Wire resolution
  // ********
  logic [31:0] flt_r = 32'h5555_5555;
  // An undriven pin without a pull toggles, so a stale level never passes for a real one.
  always_ff @(posedge clock)
    flt_r <= ~flt_r;
  always_comb
    pad_in = pad_oe & pad_out | ~pad_oe & (drv_en & drv | ~drv_en & (pull_up | ~pull_dn & flt_r));
endmodule // gpc_board

// ==== gpc_top_tb.sv ====
`timescale 1ns/1ps
`include "gpc_cfg.svh"
module gpc_top_tb;
  import gpc_pkg::*;
  logic        clock, reset_n, wr_stb, rd_stb, irq, wake, sys_reset;
  gpc_addr_t   addr;
  gpc_word_t   wdata, rdata, v;
  logic [31:0] pad_in, pad_out, pad_oe, pull_up, pull_dn, slew_lim, alt_out, alt_oe, alt_in, ext_drv, ext_en;
  logic [63:0] drive_str, alt_sel;
  int          error_cnt, checks, cyc_cnt;
  gpc_det_t    det_c[6] = '{`GPC_DET_LOW, `GPC_DET_HIGH, `GPC_DET_RISE, `GPC_DET_FALL, `GPC_DET_BOTH, `GPC_DET_OFF};
  logic [5:0]  lvl = 6'b110110, hit = 6'b011111, relvl = 6'b000011;

  gpc_top #(.PINS(32), .RST_PIN(31)) i_dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up(pull_up), .pull_dn(pull_dn), .drive_str(drive_str), .slew_lim(slew_lim), .alt_out(alt_out),
    .alt_oe(alt_oe), .alt_in(alt_in), .alt_sel(alt_sel), .irq(irq), .wake(wake), .sys_reset(sys_reset));
  gpc_board i_board (.clock(clock), .drv(ext_drv), .drv_en(ext_en), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up(pull_up), .pull_dn(pull_dn), .pad_in(pad_in));

  // ********
  // Bus tasks and checks
  // ********
  always #10 clock = ~clock;
  always @(posedge clock)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      error_cnt++;
      final_report();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Both tasks let an edge pass after dropping the strobe, so no strobe is driven twice in one step.
  task automatic wr(input gpc_addr_t a, input gpc_word_t d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input gpc_addr_t a, output gpc_word_t d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask
  task automatic chk(input string nm, input gpc_word_t got, input gpc_word_t exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdchk(input gpc_addr_t a, input gpc_word_t exp);
    rd(a, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask
  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  initial
  begin
    {clock, reset_n, wr_stb, rd_stb} = 4'h0;
    {addr, wdata, alt_out, alt_oe} = '0;
    ext_drv = 32'h8000_0000;
    ext_en = '1;
    cyc(12);
    reset_n <= 1'b1;
    cyc(1);
    rdchk(12'h004, 32'h0000_0040);
    rdchk(12'h204, 32'h0);
    rdchk(12'h7fc, 32'h0);
    chk("sys_reset", 32'(sys_reset), 32'h0);
    ext_drv <= 32'h8000_00a5;
    cyc(4);
    rdchk(12'h404, 32'h8000_00a5);
    chk("alt_in", alt_in, 32'h8000_00a5);
    wr(12'h004, 32'h0100_0040);
    rdchk(12'h004, 32'h0000_0040);
    wr(12'h000, 32'h0001_0240);
    cyc(1);
    chk("pin0", 32'({pad_oe[0], pad_out[0]}), 32'h3);
    ext_drv[0] <= 1'b0;
    wr(12'h000, 32'h0001_0340);
    cyc(3);
    chk("pin0", 32'({pad_oe[0], pad_out[0]}), 32'h0);
    rdchk(12'h000, 32'h0001_0340);
    wr(12'h000, 32'h0000_0340);
    cyc(1);
    chk("pin0", 32'({pad_oe[0], pad_out[0]}), 32'h2);
    wr(12'h004, 32'h0000_0640);
    wr(12'h400, 32'h0000_0002);
    cyc(1);
    chk("pin1", 32'({pad_oe[1], pad_out[1]}), 32'h3);
    wr(12'h400, 32'h0);
    cyc(1);
    chk("pin1", 32'(pad_out[1]), 32'h0);
    ext_en[0] <= 1'b0;
    wr(12'h000, 32'h0000_0041);
    cyc(3);
    rdchk(12'h000, 32'h0100_0041);
    wr(12'h000, 32'h0000_0042);
    cyc(3);
    rdchk(12'h000, 32'h0000_0042);
    chk("pull", 32'({pull_up[0], pull_dn[0]}), 32'h1);
    ext_en[0] <= 1'b1;
    wr(12'h200, 32'h0000_0021);
    cyc(1);
    chk("drive", 32'({drive_str[1:0], slew_lim[0]}), 32'h5);
    {alt_out[4], alt_oe[4]} <= 2'h3;
    wr(12'h010, 32'h0000_1040);
    cyc(1);
    chk("pin4", 32'({alt_sel[9:8], pad_oe[4], pad_out[4]}), 32'h7);
    wr(12'h40c, 32'h4);
    wr(12'h410, 32'h4);
    for (int i = 0; i < 6; i++)
    begin
      ext_drv[2] <= ~lvl[i];
      cyc(4);
      wr(12'h008, {25'h0, det_c[i], 4'h0});
      cyc(2);
      rd(12'h408, v);
      ext_drv[2] <= lvl[i];
      cyc(5);
      chk("irq", 32'(irq), 32'(hit[i]));
      chk("wake", 32'(wake), 32'(hit[i]));
      rdchk(12'h408, {29'h0, hit[i], 2'h0});
      rdchk(12'h408, {29'h0, relvl[i], 2'h0});
    end
    wr(12'h008, 32'h0000_0010);
    cyc(4);
    wr(12'h40c, 32'h0);
    wr(12'h410, 32'h0);
    cyc(1);
    chk("irq", 32'(irq), 32'h0);
    chk("wake", 32'(wake), 32'h0);
    wr(12'h07c, 32'h0000_3040);
    ext_drv[31] <= 1'b0;
    cyc(5);
    chk("sys_reset", 32'(sys_reset), 32'h1);
    reset_n <= 1'b0;
    cyc(3);
    reset_n <= 1'b1;
    cyc(1);
    chk("pad_oe", pad_oe, 32'h0);
    rdchk(12'h07c, 32'h0000_0040);
    final_report();
  end
endmodule // gpc_top_tb
